// File: test_timer8_interval_capture.sv
// Self-checking bench for the eight-bit interval/capture timer.
// Assumes the design, checker and edge source are compiled first.
`timescale 1ns/1ps
module test_timer8_interval_capture;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, v, d0;
  logic ext_edge_input, match_a_irq, match_b_irq, edge_irq, rtp_trigger;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  always #5 mclk = ~mclk;
  tmr8_timer DUT (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .ext_edge_input, .match_a_irq, .match_b_irq, .edge_irq,
    .rtp_trigger);
  tmr8_edge_src src (.mclk, .ext_edge_input);
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic chk_n(input string s, input int g, input int e);
    n_tests++;
    if (g != e) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", s, e, g);
    end
  endtask : chk_n
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
    input string s);
    logic [7:0] d;
    rd(a, d);
    chk(s, d, e);
  endtask : rdc
  // Bounded wait on one event output: 0 match a, 1 match b, 2 edge
  task automatic waitev(input int i, input int lim, output int c);
    logic [2:0] s;
    c = 0;
    do begin
      @(posedge mclk);
      #1 s = {edge_irq, match_b_irq, match_a_irq};
      c++;
    end while (s[i] !== 1'b1 && c < lim);
    if (c >= lim) begin
      chk_n("wait", c, -1);
      stop_test();
    end
  endtask : waitev
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(3'h0, 8'h00, "counter");
    rdc(3'h7, 8'h00, "unmapped");
    wr(3'h0, 8'h33);
    rdc(3'h0, 8'h00, "counter ro");
    wr(3'h1, 8'h5a);
    rdc(3'h1, 8'h5a, "match a");
    $display("regs done");
    wr(3'h2, 8'h03);
    wr(3'h1, 8'h01);
    wr(3'h5, 8'h01);
    wr(3'h3, 8'h08);
    for (int k = 0; k < 6; k++) begin
      wr(3'h4, 8'(k));
      waitev(0, 2100, n);
      waitev(0, 1100, n);
      chk_n("interval", n, 32 << k);
    end
    $display("interval done");
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h3, 8'h08);
    waitev(1, 100, n);
    repeat (4200) @(posedge mclk);
    rdc(3'h3, 8'h09, "wrap");
    wr(3'h3, 8'h08);
    rdc(3'h3, 8'h08, "wrap clr");
    wr(3'h3, 8'h00);
    repeat (40) @(posedge mclk);
    rdc(3'h0, 8'h00, "stopped");
    $display("wrap done");
    wr(3'h5, 8'h02);
    wr(3'h6, 8'h02);
    wr(3'h3, 8'h08);
    // Let the restart clear pass so every tick counts up
    repeat (20) @(posedge mclk);
    src.set(1'b1);
    rd(3'h2, d0);
    repeat (77) @(posedge mclk);
    src.set(1'b0);
    waitev(2, 4, n);
    rd(3'h2, v);
    chk("width", v - d0, 8'h05);
    $display("capture done");
    wr(3'h6, 8'h01);
    src.set(1'b1);
    waitev(2, 4, n);
    src.set(1'b0);
    @(posedge mclk);
    #1 chk("rise only", {7'h00, edge_irq}, 8'h00);
    wr(3'h6, 8'h00);
    src.set(1'b1);
    @(posedge mclk);
    #1 chk("fall only", {7'h00, edge_irq}, 8'h00);
    src.set(1'b0);
    waitev(2, 4, n);
    $display("edge modes done");
    stop_test();
  end
endmodule : test_timer8_interval_capture
bind tmr8_timer tmr8_chk u_chk (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .ext_edge_input, .match_a_irq, .match_b_irq,
  .edge_irq, .rtp_trigger);

// File: tmr8_chk_sva.sv
// Port checker for the eight-bit interval/capture timer.
// Assumes it is bound to tmr8_timer; one clock, mclk.
`timescale 1ns/1ps
module tmr8_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_edge_input,
  input wire logic match_a_irq,
  input wire logic match_b_irq,
  input wire logic edge_irq,
  input wire logic rtp_trigger
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Match a stays low for 8 cycles after each pulse
  sequence s_quiet_a;
    !match_a_irq [*8];
  endsequence
  sequence s_wr_rd_a;
    reg_wr && reg_addr == 3'h1 ##1 !reg_wr ##1 reg_rd && reg_addr == 3'h1;
  endsequence
  property p_reset;
    $rose(rst_n) |-> !match_a_irq && !match_b_irq && !edge_irq
      && !rtp_trigger && reg_rdata == 8'h00;
  endproperty
  property p_a_gap;
    match_a_irq |=> s_quiet_a;
  endproperty
  property p_rtp_a;
    match_a_irq |-> rtp_trigger;
  endproperty
  property p_rtp_src;
    rtp_trigger |-> match_a_irq || match_b_irq;
  endproperty
  property p_edge_src;
    edge_irq |-> $past(ext_edge_input) != $past(ext_edge_input, 2);
  endproperty
  property p_rd_wo;
    reg_rd && reg_addr >= 3'h4 |=> reg_rdata == 8'h00;
  endproperty
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  property p_match_rw;
    s_wr_rd_a |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not clear after reset");
  a_a_gap: assert property (p_a_gap)
    else $error("match a pulse too long");
  a_rtp_a: assert property (p_rtp_a)
    else $error("no output trigger on match a");
  a_rtp_src: assert property (p_rtp_src)
    else $error("output trigger without match");
  a_edge_src: assert property (p_edge_src)
    else $error("edge event without input change");
  a_rd_wo: assert property (p_rd_wo)
    else $error("write-only register read nonzero");
  a_hold: assert property (p_hold)
    else $error("read data moved without read");
  a_match_rw: assert property (p_match_rw)
    else $error("match a readback wrong");
endmodule : tmr8_chk

// File: tmr8_consts.svh
// Offsets, field positions, reset values and divider codes of the
// eight-bit interval/capture timer.
// Assumes inclusion by bare name from the timer design files.
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices on the internal bus
// ----------------------------------------------------------------
`define TMR8_IDX_COUNTER 3'h0
`define TMR8_IDX_MATCH_A 3'h1
`define TMR8_IDX_REG_B 3'h2
`define TMR8_IDX_CONTROL 3'h3
`define TMR8_IDX_DIV_SEL 3'h4
`define TMR8_IDX_CC_CFG 3'h5
`define TMR8_IDX_EDGE_MODE 3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR8_CTL_WRAP 0
`define TMR8_CTL_RUN 3
`define TMR8_CFG_CLR_A 0
`define TMR8_CFG_CAPTURE 1
`define TMR8_CFG_CLR_B 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_NIBBLE 4'h0
`define TMR8_RST_EDGE 2'h0

// ----------------------------------------------------------------
// Divider select codes: count clock = mclk / (16 << code)
// ----------------------------------------------------------------
`define TMR8_DIV_16 4'h0
`define TMR8_DIV_32 4'h1
`define TMR8_DIV_64 4'h2
`define TMR8_DIV_128 4'h3
`define TMR8_DIV_256 4'h4
`define TMR8_DIV_512 4'h5

// Edge select codes
`define TMR8_EDGE_FALL 2'h0
`define TMR8_EDGE_RISE 2'h1

`endif

// File: tmr8_edge_src.sv
// Far-side source of the external edge input.
// Assumes callers run in the mclk domain.
`timescale 1ns/1ps
module tmr8_edge_src (
  input wire logic mclk,
  output logic ext_edge_input
);
  initial ext_edge_input = 1'b0;
  task automatic set(input logic v);
    @(posedge mclk);
    ext_edge_input <= v;
  endtask : set
endmodule : tmr8_edge_src

// File: tmr8_pkg.sv
// Types of the eight-bit interval/capture timer.
// Assumes the consts header is read alongside; holds no numbers itself.
package tmr8_pkg;

  // ----------------------------------------------------------------
  // Prescaler state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] div;
    logic tick;
  } tmr8_pre_state_t;

  // ----------------------------------------------------------------
  // Timer state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] match_a;
    logic [7:0] reg_b;
    logic run;
    logic wrap;
    logic clr_pend;
    logic [3:0] div_sel;
    logic clr_a;
    logic capture;
    logic clr_b;
    logic [1:0] edge_sel;
    logic edge_prev;
    logic irq_a;
    logic irq_b;
    logic irq_edge;
    logic rtp;
    logic [7:0] rdata;
  } tmr8_state_t;

endpackage : tmr8_pkg

// File: tmr8_prescaler.sv
// Free-running divider giving one-cycle count clock enables.
// Assumes a single clock mclk with synchronous active-low reset.
`timescale 1ns/1ps
`include "tmr8_consts.svh"

module tmr8_prescaler #(
  parameter int DIV_W = 9
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] div_sel,
  output logic tick
);

  tmr8_pkg::tmr8_pre_state_t s_q;
  tmr8_pkg::tmr8_pre_state_t s_d;
  logic [8:0] mask;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 9'h001;
    unique case (div_sel)
      `TMR8_DIV_16: mask = 9'h00f;
      `TMR8_DIV_32: mask = 9'h01f;
      `TMR8_DIV_64: mask = 9'h03f;
      `TMR8_DIV_128: mask = 9'h07f;
      `TMR8_DIV_256: mask = 9'h0ff;
      `TMR8_DIV_512: mask = 9'h1ff;
      // Unused codes give no count clock at all
      default: mask = 9'h000;
    endcase
    s_d.tick = (mask != 9'h000) && ((s_q.div & mask) == mask);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : tmr8_prescaler

// File: tmr8_timer.sv
// Eight-bit up counter with match register, capture/compare register
// and an internal-bus register port.
// Assumes bus and edge input are synchronous to mclk.
`timescale 1ns/1ps
`include "tmr8_consts.svh"

module tmr8_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ext_edge_input,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic edge_irq,
  output logic rtp_trigger
);

  tmr8_pkg::tmr8_state_t s_q;
  tmr8_pkg::tmr8_state_t s_d;
  logic tick;
  logic [7:0] new_cnt;
  logic edge_seen;
  logic wrap_now;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [2:0] addr,
                               input logic [2:0] idx);
    hit = (addr == idx);
  endfunction : hit

  function automatic logic edge_ok(input logic [1:0] mode,
                                   input logic prev,
                                   input logic now);
    unique case (mode)
      `TMR8_EDGE_FALL: edge_ok = prev && !now;
      `TMR8_EDGE_RISE: edge_ok = !prev && now;
      // Codes 2 and 3 take both edges
      default: edge_ok = prev != now;
    endcase
  endfunction : edge_ok

  // True when this count clock carries the counter past its top
  function automatic logic wraps_now(input logic tk,
                                     input logic run,
                                     input logic pend,
                                     input logic [7:0] cnt);
    wraps_now = tk && run && !pend && (cnt == 8'hff);
  endfunction : wraps_now

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  tmr8_prescaler #(
    .DIV_W(9)
  ) u_pre (
    .mclk(mclk),
    .rst_n(rst_n),
    .div_sel(s_q.div_sel),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq_a = 1'b0;
    s_d.irq_b = 1'b0;
    s_d.irq_edge = 1'b0;
    s_d.rtp = 1'b0;
    s_d.edge_prev = ext_edge_input;
    new_cnt = s_q.cnt;
    edge_seen = edge_ok(s_q.edge_sel, s_q.edge_prev, ext_edge_input);
    wrap_now = wraps_now(tick, s_q.run, s_q.clr_pend, s_q.cnt);

    // Counter: a pending clear is served first, so the counter holds
    // its old value until the next count clock.
    if (tick) begin
      if (s_q.clr_pend) begin
        new_cnt = 8'h00;
        s_d.clr_pend = 1'b0;
      end else if (s_q.run) begin
        new_cnt = s_q.cnt + 8'h01;
        if (wrap_now) begin
          s_d.wrap = 1'b1;
        end
      end
      s_d.cnt = new_cnt;
      if (s_q.run) begin
        // Match checked only on a fresh counter value
        // A clear raised here is served at the next count clock
        if (new_cnt == s_q.match_a) begin
          s_d.irq_a = 1'b1;
          s_d.rtp = 1'b1;
          if (s_q.clr_a) begin
            s_d.clr_pend = 1'b1;
          end
        end
        if (!s_q.capture && new_cnt == s_q.reg_b) begin
          s_d.irq_b = 1'b1;
          s_d.rtp = 1'b1;
          if (s_q.clr_b) begin
            s_d.clr_pend = 1'b1;
          end
        end
      end
    end

    // Edge input raises its own request in any mode
    // No width filter: a one-cycle glitch counts as an edge
    if (edge_seen) begin
      s_d.irq_edge = 1'b1;
    end

    // Register writes; the counter itself is not writable
    if (reg_wr) begin
      if (hit(reg_addr, `TMR8_IDX_MATCH_A)) begin
        s_d.match_a = reg_wdata;
      end
      if (hit(reg_addr, `TMR8_IDX_REG_B)) begin
        s_d.reg_b = reg_wdata;
      end
      if (hit(reg_addr, `TMR8_IDX_CONTROL)) begin
        s_d.run = reg_wdata[`TMR8_CTL_RUN];
        // Setting run again while running must not restart the count
        if (reg_wdata[`TMR8_CTL_RUN] != s_q.run) begin
          s_d.clr_pend = 1'b1;
        end
        // Hardware wrap in the same cycle beats a software clear
        s_d.wrap = reg_wdata[`TMR8_CTL_WRAP] || s_d.wrap;
        if (!reg_wdata[`TMR8_CTL_WRAP] && !wrap_now) begin
          s_d.wrap = 1'b0;
        end
      end
      if (hit(reg_addr, `TMR8_IDX_DIV_SEL)) begin
        // Only the low nibble picks a divider
        s_d.div_sel = reg_wdata[3:0];
      end
      if (hit(reg_addr, `TMR8_IDX_CC_CFG)) begin
        s_d.clr_a = reg_wdata[`TMR8_CFG_CLR_A];
        s_d.capture = reg_wdata[`TMR8_CFG_CAPTURE];
        s_d.clr_b = reg_wdata[`TMR8_CFG_CLR_B];
      end
      if (hit(reg_addr, `TMR8_IDX_EDGE_MODE)) begin
        s_d.edge_sel = reg_wdata[1:0];
      end
    end

    // Capture beats a software write to register B in the same cycle;
    // the captured value is the counter as it stands now.
    if (s_q.run && s_q.capture && edge_seen) begin
      s_d.reg_b = s_q.cnt;
      if (s_q.clr_b) begin
        s_d.clr_pend = 1'b1;
      end
    end

    // Reads answer one cycle later; write-only registers read zero
    if (reg_rd) begin
      s_d.rdata = 8'h00;
      if (hit(reg_addr, `TMR8_IDX_COUNTER)) begin
        s_d.rdata = s_q.cnt;
      end
      if (hit(reg_addr, `TMR8_IDX_MATCH_A)) begin
        s_d.rdata = s_q.match_a;
      end
      if (hit(reg_addr, `TMR8_IDX_REG_B)) begin
        s_d.rdata = s_q.reg_b;
      end
      if (hit(reg_addr, `TMR8_IDX_CONTROL)) begin
        // Other control bits read as zero
        s_d.rdata[`TMR8_CTL_RUN] = s_q.run;
        s_d.rdata[`TMR8_CTL_WRAP] = s_q.wrap;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Match registers start at zero rather than unknown
      s_q <= '0;
      s_q.cnt <= `TMR8_RST_BYTE;
      s_q.div_sel <= `TMR8_RST_NIBBLE;
      s_q.edge_sel <= `TMR8_RST_EDGE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign match_a_irq = s_q.irq_a;
  assign match_b_irq = s_q.irq_b;
  assign edge_irq = s_q.irq_edge;
  assign rtp_trigger = s_q.rtp;

endmodule : tmr8_timer
